/* File: burst_sram.sv */
// Behaviour
// - Address, data, byte writes registered on edge
// - 32K words of 18 bits, shared bus
// - Counter cleared at begin, XORed into low address bits
// - Visit remaining three words of group
// - Step low advances, step high suspends
// - Begin burst: processor reads, controller reads/writes
// - Both strobes high, step low: continue burst
// - Suspended write rewrites current address
// - Suspended read rereads current address
// - Gated processor strobe loads no address; step low still advances
// - Controller strobe with select high: power down
// - Strobe with select low: power up
// - Only begin cycles leave power down
// - Output enable acts asynchronously
// - Bus driven only on enabled reads
module burst_sram (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [burst_sram_pkg::ADDR_W-1:0] word_address_i,
   input wire logic [burst_sram_pkg::DATA_W-1:0] data_bus_i,
   output logic [burst_sram_pkg::DATA_W-1:0] data_bus_o,
   output logic data_bus_oe_o,
   input wire logic chip_select_n_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic burst_step_n_i,
   input wire logic upper_byte_write_n_i,
   input wire logic lower_byte_write_n_i,
   input wire logic output_enable_n_i,
   output logic write_ready_o,
   output logic powered_up_o
);
   typedef struct packed {
      logic [burst_sram_pkg::ADDR_W-1:0] base;
      logic [burst_sram_pkg::CNT_W-1:0] cnt;
      logic [burst_sram_pkg::ADDR_W-1:0] wr_addr;
      logic [burst_sram_pkg::DATA_W-1:0] wr_data;
      logic [burst_sram_pkg::LANES-1:0] wr_lanes;
      logic wr_pend;
      logic rd_valid;
      logic powered;
   } ctrl_state_t;

   ctrl_state_t cur_ff;
   ctrl_state_t nxt_ff;
   burst_sram_pkg::cycle_t cycle;
   logic [burst_sram_pkg::DATA_W-1:0] rdata_ff;
   logic [burst_sram_pkg::ADDR_W-1:0] nxt_addr;
   logic [burst_sram_pkg::LANES-1:0] lanes_in;
   logic [burst_sram_pkg::ENTRY_W-1:0] drain_entry;
   logic drain_valid;
   logic drain_ready;
   logic [burst_sram_pkg::ADDR_W-1:0] drain_addr;
   logic [burst_sram_pkg::DATA_W-1:0] drain_data;
   logic [burst_sram_pkg::LANES-1:0] drain_lanes;

   function automatic burst_sram_pkg::cycle_t decode_cycle(
      input logic cs_n,
      input logic ap_n,
      input logic ac_n,
      input logic step_n,
      input logic any_wr
   );
      burst_sram_pkg::cycle_t c;
      c = burst_sram_pkg::CYC_HOLD_READ;
      if (cs_n && !ac_n)
         c = burst_sram_pkg::CYC_DESELECT;
      else if (!cs_n && !ap_n)
         c = burst_sram_pkg::CYC_BEGIN_READ;
      else if (!cs_n && !ac_n)
         c = any_wr ? burst_sram_pkg::CYC_BEGIN_WRITE : burst_sram_pkg::CYC_BEGIN_READ;
      else if (!step_n)
         c = any_wr ? burst_sram_pkg::CYC_NEXT_WRITE : burst_sram_pkg::CYC_NEXT_READ;
      else
         c = any_wr ? burst_sram_pkg::CYC_HOLD_WRITE : burst_sram_pkg::CYC_HOLD_READ;
      return c;
   endfunction

   // Active-low lane enables turned into a lane mask
   assign lanes_in = {~upper_byte_write_n_i, ~lower_byte_write_n_i};

   assign cycle = decode_cycle(chip_select_n_i, processor_addr_strobe_n_i, controller_addr_strobe_n_i,
                               burst_step_n_i, |lanes_in);

   always_comb
   begin
      nxt_ff = cur_ff;
      nxt_ff.wr_pend = 1'b0;
      nxt_ff.rd_valid = 1'b0;
      case (cycle)
         burst_sram_pkg::CYC_DESELECT:
         begin
            nxt_ff.powered = 1'b0;
         end
         burst_sram_pkg::CYC_BEGIN_READ,
         burst_sram_pkg::CYC_BEGIN_WRITE:
         begin
            nxt_ff.base = word_address_i;
            nxt_ff.cnt = burst_sram_pkg::CNT_RESET;
            nxt_ff.powered = 1'b1;
         end
         burst_sram_pkg::CYC_NEXT_READ,
         burst_sram_pkg::CYC_NEXT_WRITE:
         begin
            nxt_ff.cnt = cur_ff.cnt + burst_sram_pkg::CNT_STEP;
         end
         burst_sram_pkg::CYC_HOLD_READ,
         burst_sram_pkg::CYC_HOLD_WRITE:
         begin
            nxt_ff.cnt = cur_ff.cnt;
         end
         default:
         begin
            nxt_ff.cnt = cur_ff.cnt;
         end
      endcase
      // Low pair is base XOR a plain 0..3 count
      nxt_addr = {nxt_ff.base[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::CNT_W],
                  nxt_ff.base[burst_sram_pkg::CNT_W-1:0] ^ nxt_ff.cnt};
      if (cycle == burst_sram_pkg::CYC_BEGIN_WRITE || cycle == burst_sram_pkg::CYC_NEXT_WRITE ||
          cycle == burst_sram_pkg::CYC_HOLD_WRITE)
      begin
         nxt_ff.wr_pend = 1'b1;
         nxt_ff.wr_addr = nxt_addr;
         nxt_ff.wr_data = data_bus_i;
         nxt_ff.wr_lanes = lanes_in;
      end
      else if (cycle != burst_sram_pkg::CYC_DESELECT)
      begin
         nxt_ff.rd_valid = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cur_ff.base <= burst_sram_pkg::ADDR_RESET;
         cur_ff.cnt <= burst_sram_pkg::CNT_RESET;
         cur_ff.wr_addr <= burst_sram_pkg::ADDR_RESET;
         cur_ff.wr_data <= burst_sram_pkg::DATA_RESET;
         cur_ff.wr_lanes <= burst_sram_pkg::LANES_RESET;
         cur_ff.wr_pend <= 1'b0;
         cur_ff.rd_valid <= 1'b0;
         cur_ff.powered <= burst_sram_pkg::POWER_RESET;
      end
      else
      begin
         cur_ff <= nxt_ff;
      end
   end

   // Writes queue here so the array write can lag the bus cycle
   write_fifo #(
      .WIDTH(burst_sram_pkg::ENTRY_W),
      .DEPTH(burst_sram_pkg::FIFO_DEPTH)
   ) u_write_fifo (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .in_valid_i(cur_ff.wr_pend),
      .in_ready_o(write_ready_o),
      .in_data_i({cur_ff.wr_addr, cur_ff.wr_data, cur_ff.wr_lanes}),
      .out_valid_o(drain_valid),
      .out_ready_i(drain_ready),
      .out_data_o(drain_entry)
   );

   // The array sleeps while powered down, so queued writes wait
   assign drain_ready = cur_ff.powered;
   assign drain_addr = drain_entry[burst_sram_pkg::ENTRY_W-1 -: burst_sram_pkg::ADDR_W];
   assign drain_data = drain_entry[burst_sram_pkg::DATA_W+burst_sram_pkg::LANES-1 -: burst_sram_pkg::DATA_W];
   assign drain_lanes = drain_entry[burst_sram_pkg::LANES-1:0];

   // One array per lane, so each lane has a single writing process
   // No reset on the read register: its contents only show when rd_valid is set
   generate
      for (genvar lane = 0; lane < burst_sram_pkg::LANES; lane++)
      begin : g_lane
         logic [burst_sram_pkg::LANE_W-1:0] lane_mem [burst_sram_pkg::WORDS];
         always_ff @(posedge mclk_i)
         begin
            if (drain_valid && drain_ready && drain_lanes[lane])
               lane_mem[drain_addr] <= drain_data[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
            rdata_ff[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] <= lane_mem[nxt_addr];
         end
      end
   endgenerate

   assign data_bus_o = rdata_ff;
   // Enable is combinational on output_enable_n_i for the asynchronous turn-off
   assign data_bus_oe_o = cur_ff.rd_valid && cur_ff.powered && !output_enable_n_i;
   assign powered_up_o = cur_ff.powered;
endmodule

/* File: burst_sram_pkg.sv */
package burst_sram_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES = 2;
   localparam int CNT_W = 2;
   localparam int WORDS = 32768;
   localparam int FIFO_DEPTH = 4;
   localparam int UPPER_LANE = 1;
   localparam int LOWER_LANE = 0;
   localparam int ENTRY_W = ADDR_W + DATA_W + LANES;
   localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
   localparam logic [LANES-1:0] LANES_RESET = 2'h0;
   localparam logic POWER_RESET = 1'b0;

   typedef enum logic [2:0] {
      CYC_DESELECT,
      CYC_BEGIN_READ,
      CYC_BEGIN_WRITE,
      CYC_NEXT_READ,
      CYC_NEXT_WRITE,
      CYC_HOLD_READ,
      CYC_HOLD_WRITE
   } cycle_t;
endpackage

/* File: write_fifo.sv */
module write_fifo #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 4
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic [PTR_W-1:0] rd_ptr;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W:0] count;
   } fifo_state_t;

   fifo_state_t cur_ff;
   fifo_state_t nxt_ff;
   logic push;
   logic pop;

   // Count is one bit wider than the pointers so that full and empty differ
   assign in_ready_o = (cur_ff.count != (PTR_W + 1)'(DEPTH));
   assign out_valid_o = (cur_ff.count != '0);
   assign out_data_o = cur_ff.slot[cur_ff.rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb
   begin
      nxt_ff = cur_ff;
      if (push)
      begin
         nxt_ff.slot[cur_ff.wr_ptr] = in_data_i;
         nxt_ff.wr_ptr = (cur_ff.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : cur_ff.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         nxt_ff.rd_ptr = (cur_ff.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : cur_ff.rd_ptr + 1'b1;
      end
      case ({push, pop})
         2'b10: nxt_ff.count = cur_ff.count + 1'b1;
         2'b01: nxt_ff.count = cur_ff.count - 1'b1;
         default: nxt_ff.count = cur_ff.count;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cur_ff <= '0;
      else
         cur_ff <= nxt_ff;
   end
endmodule

/* File: burst_sram_properties.sv */
module burst_sram_properties (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic chip_select_n_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic upper_byte_write_n_i,
   input wire logic lower_byte_write_n_i,
   input wire logic output_enable_n_i,
   input wire logic data_bus_oe_o,
   input wire logic powered_up_o
);
   wire sel = !chip_select_n_i;
   wire pstb = !processor_addr_strobe_n_i;
   wire cstb = !controller_addr_strobe_n_i;
   wire wr = !(upper_byte_write_n_i && lower_byte_write_n_i);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   AST_OE_ASYNC: assert property (output_enable_n_i |-> !data_bus_oe_o)
      else $error("bus driven with output enable off");
   AST_DOWN_HIZ: assert property (!powered_up_o |-> !data_bus_oe_o)
      else $error("bus driven while powered down");
   AST_PWR_DOWN: assert property (!sel && cstb |=> !powered_up_o)
      else $error("deselect did not power down");
   AST_PWR_UP: assert property (sel && (pstb || cstb) |=> powered_up_o)
      else $error("begin cycle did not power up");
   AST_PWR_KEEP: assert property (!cstb && !(sel && pstb) |=> $stable(powered_up_o))
      else $error("power state changed without begin or deselect");
   AST_READ_DRIVE: assert property (sel && pstb && !output_enable_n_i |=> data_bus_oe_o || output_enable_n_i)
      else $error("begin read did not drive bus");
   AST_WRITE_HIZ: assert property (!pstb && wr |=> !data_bus_oe_o)
      else $error("bus driven after write cycle");
   AST_DESEL_HIZ: assert property (!sel && cstb ##1 !cstb && !(sel && pstb) |=> !data_bus_oe_o)
      else $error("read after deselect drove bus");
   COV_BEGIN_READ: cover property (sel && pstb ##1 data_bus_oe_o);
   COV_WRITE: cover property (!pstb && !cstb && wr);
   COV_DOWN_UP: cover property (!powered_up_o ##1 powered_up_o);
endmodule

/* File: bus_partner.sv */
module bus_partner (
   input wire logic mclk_i,
   input wire logic dev_oe_i,
   input wire logic [17:0] dev_data_i,
   input wire logic host_oe_i,
   input wire logic [17:0] host_data_i,
   output logic [17:0] bus_o
);
   logic [17:0] last_ff;
   // Released bus shows the inverse of its last level, so stale data never passes
   always_ff @(posedge mclk_i)
   begin
      last_ff <= bus_o;
   end
   always_comb
   begin
      bus_o = ~last_ff;
      if (host_oe_i) bus_o = host_data_i;
      if (dev_oe_i) bus_o = dev_data_i;
   end
endmodule

/* File: tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] ctl = 6'h3F;
   logic oe_n = 1'b1;
   logic hoe = 1'b1;
   logic [14:0] adr = 15'h0000;
   logic [17:0] wdat = 18'h00000;
   logic [17:0] bus, dout, pexp;
   logic doe, wrdy, pwr_o;
   logic [17:0] mem [logic [14:0]];
   logic [14:0] base = 15'h0000;
   logic [1:0] cnt = 2'h0;
   logic pwr = 1'b0;
   logic pend = 1'b0;
   logic pv = 1'b0;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   burst_sram burst_sram_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .word_address_i(adr), .data_bus_i(bus),
      .data_bus_o(dout), .data_bus_oe_o(doe), .chip_select_n_i(ctl[5]), .processor_addr_strobe_n_i(ctl[4]),
      .controller_addr_strobe_n_i(ctl[3]), .burst_step_n_i(ctl[2]), .upper_byte_write_n_i(ctl[1]),
      .lower_byte_write_n_i(ctl[0]), .output_enable_n_i(oe_n), .write_ready_o(wrdy), .powered_up_o(pwr_o));
   bus_partner bus_partner_inst (.mclk_i(mclk_i), .dev_oe_i(doe), .dev_data_i(dout), .host_oe_i(hoe),
      .host_data_i(wdat), .bus_o(bus));
   initial
   begin
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Outputs of an edge are judged at the next falling edge, one call late
   task automatic cyc(input logic [5:0] c, input logic [14:0] a, input logic [17:0] d);
      logic wr, dsl;
      logic [14:0] ea;
      logic [17:0] nv;
      @(posedge mclk_i);
      dsl = c[5] && !c[3];
      wr = !(c[1] && c[0]) && !dsl && !(!c[5] && !c[4]);
      ctl <= c;
      adr <= a;
      wdat <= d;
      hoe <= wr;
      oe_n <= wr;
      @(negedge mclk_i);
      // A write cycle raises output enable at once, so the pending read is no longer driven
      chk(doe, pend && !wr);
      chk(pwr_o, pwr);
      if (pend && pv) chk(dout, pexp);
      if (dsl) pwr = 1'b0;
      else if (!c[5] && !(c[4] && c[3]))
      begin
         base = a;
         cnt = 2'h0;
         pwr = 1'b1;
      end
      else if (!c[2]) cnt = cnt + 2'h1;
      ea = {base[14:2], base[1:0] ^ cnt};
      pv = mem.exists(ea);
      nv = pv ? mem[ea] : 18'h00000;
      if (wr && !c[1]) nv[17:9] = d[17:9];
      if (wr && !c[0]) nv[8:0] = d[8:0];
      if (wr) mem[ea] = nv;
      if (wr) pv = 1'b1;
      pexp = nv;
      pend = !wr && !dsl && pwr;
   endtask
   task automatic t_write_burst();
      cyc(6'h0F, 15'h0100, 18'h00000);
      cyc(6'h14, 15'h0101, 18'h11111);
      cyc(6'h18, 15'h0000, 18'h22222);
      cyc(6'h1C, 15'h0000, 18'h2AAAA);
      cyc(6'h38, 15'h0000, 18'h33333);
      cyc(6'h18, 15'h0000, 18'h04444);
      cyc(6'h19, 15'h0000, 18'h3FE00);
      cyc(6'h1A, 15'h0000, 18'h001FF);
      repeat (3) cyc(6'h0F, 15'h0200, 18'h00000);
   endtask
   task automatic t_read_burst();
      cyc(6'h0F, 15'h0102, 18'h00000);
      cyc(6'h1B, 15'h0000, 18'h00000);
      cyc(6'h1F, 15'h0000, 18'h00000);
      cyc(6'h3B, 15'h0000, 18'h00000);
      cyc(6'h1B, 15'h0000, 18'h00000);
      cyc(6'h1F, 15'h0000, 18'h00000);
   endtask
   task automatic t_gate();
      cyc(6'h0F, 15'h0103, 18'h00000);
      cyc(6'h2F, 15'h0200, 18'h00000);
      cyc(6'h2B, 15'h0200, 18'h00000);
      cyc(6'h17, 15'h0100, 18'h00000);
      cyc(6'h1F, 15'h0000, 18'h00000);
   endtask
   task automatic t_oe_async();
      cyc(6'h0F, 15'h0101, 18'h00000);
      cyc(6'h1F, 15'h0000, 18'h00000);
      oe_n <= 1'b1;
      #1 chk(doe, 1'b0);
      oe_n <= 1'b0;
   endtask
   task automatic t_power();
      cyc(6'h37, 15'h0000, 18'h00000);
      for (int i = 0; i < 4; i++) cyc(6'h38, 15'h0000, {16'h1400, i[1:0]});
      repeat (2) cyc(6'h1F, 15'h0000, 18'h00000);
      chk(wrdy, 1'b0);
      cyc(6'h0F, 15'h0200, 18'h00000);
      for (int i = 0; i < 8 && wrdy !== 1'b1; i++) cyc(6'h0F, 15'h0200, 18'h00000);
      chk(wrdy, 1'b1);
      repeat (6) cyc(6'h0F, 15'h0200, 18'h00000);
      cyc(6'h0F, 15'h0100, 18'h00000);
      repeat (3) cyc(6'h1B, 15'h0000, 18'h00000);
      cyc(6'h1F, 15'h0000, 18'h00000);
   endtask
   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (16) @(posedge mclk_i);
      rstn_i <= 1'b1;
      t_write_burst();
      t_read_burst();
      t_gate();
      t_oe_async();
      t_power();
      tally_and_finish();
   end
endmodule
bind burst_sram burst_sram_properties burst_sram_properties_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .chip_select_n_i(chip_select_n_i), .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
   .controller_addr_strobe_n_i(controller_addr_strobe_n_i), .upper_byte_write_n_i(upper_byte_write_n_i),
   .lower_byte_write_n_i(lower_byte_write_n_i), .output_enable_n_i(output_enable_n_i),
   .data_bus_oe_o(data_bus_oe_o), .powered_up_o(powered_up_o));
